// [hw/auf_cfg.svh]
`ifndef AUF_CFG_SVH
`define AUF_CFG_SVH

// system clock and line rate
`define AUF_CLK_HZ        40000000
`define AUF_BAUD          115200
`define AUF_BIT_CYCLES    (`AUF_CLK_HZ / `AUF_BAUD)
`define AUF_DATA_BITS     8

// idle time on the send request between two outgoing packets
`define AUF_GAP_TIME_NS   50000
`define AUF_GAP_CYCLES    ((`AUF_GAP_TIME_NS * (`AUF_CLK_HZ / 1000000) + 999) / 1000)

// framing bytes
`define AUF_FLAG          8'h7e
`define AUF_ESC           8'h7d
`define AUF_XOR           8'h20

`endif

// [hw/auf_pkg.sv]
package auf_pkg;

    typedef enum logic [6:0] {
        TX_IDLE  = 7'h01,
        TX_REQ   = 7'h02,
        TX_OPEN  = 7'h04,
        TX_DATA  = 7'h08,
        TX_CLOSE = 7'h10,
        TX_FIN   = 7'h20,
        TX_GAP   = 7'h40
    } auf_tx_state_t;

    typedef logic [7:0] auf_byte_t;

endpackage

// [hw/auf_char_if.sv]
`timescale 1ns/1ps
interface auf_char_if;
    auf_pkg::auf_byte_t tx_byte;
    logic               tx_start;
    logic               tx_busy;
    auf_pkg::auf_byte_t rx_byte;
    logic               rx_strobe;
    logic               rx_ferr;
    logic               rx_active;

    modport engine (
        input  tx_byte,
        input  tx_start,
        output tx_busy,
        output rx_byte,
        output rx_strobe,
        output rx_ferr,
        output rx_active
    );

    modport framer (
        output tx_byte,
        output tx_start,
        input  tx_busy,
        input  rx_byte,
        input  rx_strobe,
        input  rx_ferr,
        input  rx_active
    );
endinterface

// [hw/auf_uart_char.sv]
`timescale 1ns/1ps
`include "auf_cfg.svh"
module auf_uart_char #(
    parameter int BIT_CYCLES = `AUF_BIT_CYCLES
) (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   rxd,
    output logic        txd,
    auf_char_if.engine  ch
);
    localparam int CW = $clog2(BIT_CYCLES + 1);

    if (BIT_CYCLES < 16) begin : g_chk
        $error("auf_uart_char: BIT_CYCLES too small");
    end

    logic [8:0]    tx_sh;
    logic [3:0]    tx_bits;
    logic [CW-1:0] tx_cyc;
    logic          rxd_m;
    logic          rxd_s;
    logic [7:0]    rx_sh;
    logic [3:0]    rx_bits;
    logic [CW-1:0] rx_cyc;

    // start bit, eight data bits lsb first, one stop bit, no parity
    always_ff @(posedge clk) begin
        if (rst) begin
            txd        <= 1'b1;
            ch.tx_busy <= 1'b0;
            tx_sh      <= 9'h1ff;
            tx_bits    <= 4'h0;
            tx_cyc     <= '0;
        end else if (ch.tx_start && !ch.tx_busy) begin
            txd        <= 1'b0;
            tx_sh      <= {1'b1, ch.tx_byte};
            tx_bits    <= 4'h9;
            tx_cyc     <= CW'(BIT_CYCLES - 1);
            ch.tx_busy <= 1'b1;
        end else if (ch.tx_busy) begin
            if (tx_cyc != '0) begin
                tx_cyc <= tx_cyc - CW'(1);
            end else if (tx_bits != 4'h0) begin
                txd     <= tx_sh[0];
                tx_sh   <= {1'b1, tx_sh[8:1]};
                tx_bits <= tx_bits - 4'h1;
                tx_cyc  <= CW'(BIT_CYCLES - 1);
            end else begin
                ch.tx_busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rxd_m <= 1'b1;
            rxd_s <= 1'b1;
        end else begin
            rxd_m <= rxd;
            rxd_s <= rxd_m;
        end
    end

    // sample mid-bit; stop bit low reports a framing error
    always_ff @(posedge clk) begin
        if (rst) begin
            ch.rx_active <= 1'b0;
            ch.rx_strobe <= 1'b0;
            ch.rx_ferr   <= 1'b0;
            ch.rx_byte   <= 8'h00;
            rx_sh        <= 8'h00;
            rx_bits      <= 4'h0;
            rx_cyc       <= '0;
        end else begin
            ch.rx_strobe <= 1'b0;
            ch.rx_ferr   <= 1'b0;
            if (!ch.rx_active) begin
                if (!rxd_s) begin
                    ch.rx_active <= 1'b1;
                    rx_bits      <= 4'h0;
                    rx_cyc       <= CW'(BIT_CYCLES / 2);
                end
            end else if (rx_cyc != '0) begin
                rx_cyc <= rx_cyc - CW'(1);
            end else begin
                rx_cyc  <= CW'(BIT_CYCLES - 1);
                rx_bits <= rx_bits + 4'h1;
                if (rx_bits == 4'h0) begin
                    if (rxd_s) begin
                        ch.rx_active <= 1'b0;
                    end
                end else if (rx_bits != 4'h9) begin
                    rx_sh <= {rxd_s, rx_sh[7:1]};
                end else begin
                    ch.rx_active <= 1'b0;
                    ch.rx_byte   <= rx_sh;
                    ch.rx_strobe <= 1'b1;
                    ch.rx_ferr   <= !rxd_s;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_start_bit;
        !txd [*8];
    endsequence

    chk_start_bit_low: assert property (ch.tx_start && !ch.tx_busy |=> s_start_bit)
        else $error("start bit not driven low");

    chk_busy_covers_char: assert property (ch.tx_start && !ch.tx_busy |=> ch.tx_busy [*8])
        else $error("character engine released too early");

endmodule

// [hw/auf_link.sv]
`timescale 1ns/1ps
`include "auf_cfg.svh"
module auf_link #(
    parameter int BIT_CYCLES = `AUF_BIT_CYCLES,
    parameter int GAP_CYCLES = `AUF_GAP_CYCLES
) (
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    input  wire logic       RXD,
    input  wire logic       HOST_SEND_REQUEST_N,
    output logic            NODE_ACCEPT_GRANT_N,
    output logic            TXD,
    output logic            NODE_SEND_REQUEST_N,
    input  wire logic       HOST_ACCEPT_GRANT_N,
    input  wire logic [7:0] TX_DATA,
    input  wire logic       TX_VALID,
    input  wire logic       TX_LAST,
    output logic            TX_READY,
    output logic [7:0]      RX_DATA,
    output logic            RX_VALID,
    output logic            RX_END,
    output logic            RX_ERR,
    output logic            AWAKE
);
    localparam int GW = $clog2(GAP_CYCLES + 1);

    if (GAP_CYCLES < 1 || GAP_CYCLES > 4096) begin : g_chk
        $error("auf_link: GAP_CYCLES out of range");
    end

    function automatic logic needs_escape(input auf_pkg::auf_byte_t b);
        needs_escape = (b == `AUF_FLAG) || (b == `AUF_ESC);
    endfunction

    auf_char_if ch ();

    auf_uart_char #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_char (
        .clk (CLK),
        .rst (SYS_RST),
        .rxd (RXD),
        .txd (TXD),
        .ch  (ch.engine)
    );

    auf_pkg::auf_tx_state_t st;
    auf_pkg::auf_byte_t     hold;
    logic                   hold_valid;
    logic                   hold_last;
    logic                   esc_stage;
    logic                   sent_esc;
    logic [GW-1:0]          gap_cnt;
    logic                   cts_m;
    logic                   cts_s;
    logic                   req_m;
    logic                   req_s;
    logic                   rx_esc;
    logic                   rx_any;
    logic                   can_issue;

    assign can_issue = !ch.tx_busy && !ch.tx_start;

    // handshake inputs come from the companion's domain
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cts_m <= 1'b1;
            cts_s <= 1'b1;
            req_m <= 1'b1;
            req_s <= 1'b1;
        end else begin
            cts_m <= HOST_ACCEPT_GRANT_N;
            cts_s <= cts_m;
            req_m <= HOST_SEND_REQUEST_N;
            req_s <= req_m;
        end
    end

    // transmit packet sequencer
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st                  <= auf_pkg::TX_IDLE;
            NODE_SEND_REQUEST_N <= 1'b1;
            TX_READY            <= 1'b0;
            ch.tx_start         <= 1'b0;
            ch.tx_byte          <= 8'h00;
            hold                <= 8'h00;
            hold_valid          <= 1'b0;
            hold_last           <= 1'b0;
            esc_stage           <= 1'b0;
            gap_cnt             <= '0;
        end else begin
            ch.tx_start <= 1'b0;
            if (TX_READY && TX_VALID) begin
                hold       <= TX_DATA;
                hold_last  <= TX_LAST;
                hold_valid <= 1'b1;
                TX_READY   <= 1'b0;
            end
            case (st)
                auf_pkg::TX_IDLE: begin
                    if (TX_VALID) begin
                        NODE_SEND_REQUEST_N <= 1'b0;
                        st                  <= auf_pkg::TX_REQ;
                    end
                end
                auf_pkg::TX_REQ: begin
                    if (!cts_s) begin
                        st <= auf_pkg::TX_OPEN;
                    end
                end
                auf_pkg::TX_OPEN: begin
                    if (can_issue) begin
                        ch.tx_byte  <= `AUF_FLAG;
                        ch.tx_start <= 1'b1;
                        TX_READY    <= 1'b1;
                        st          <= auf_pkg::TX_DATA;
                    end
                end
                auf_pkg::TX_DATA: begin
                    // grant is not looked at again until the packet is out
                    if (hold_valid && can_issue) begin
                        ch.tx_start <= 1'b1;
                        if (needs_escape(hold) && !esc_stage) begin
                            ch.tx_byte <= `AUF_ESC;
                            esc_stage  <= 1'b1;
                        end else begin
                            ch.tx_byte <= esc_stage ? (hold ^ `AUF_XOR) : hold;
                            esc_stage  <= 1'b0;
                            hold_valid <= 1'b0;
                            if (hold_last) begin
                                st <= auf_pkg::TX_CLOSE;
                            end else begin
                                TX_READY <= 1'b1;
                            end
                        end
                    end
                end
                auf_pkg::TX_CLOSE: begin
                    if (can_issue) begin
                        ch.tx_byte  <= `AUF_FLAG;
                        ch.tx_start <= 1'b1;
                        st          <= auf_pkg::TX_FIN;
                    end
                end
                auf_pkg::TX_FIN: begin
                    if (can_issue) begin
                        NODE_SEND_REQUEST_N <= 1'b1;
                        gap_cnt             <= GW'(GAP_CYCLES - 1);
                        st                  <= auf_pkg::TX_GAP;
                    end
                end
                auf_pkg::TX_GAP: begin
                    if (gap_cnt != '0) begin
                        gap_cnt <= gap_cnt - GW'(1);
                    end else begin
                        st <= auf_pkg::TX_IDLE;
                    end
                end
                default: begin
                    st                  <= auf_pkg::TX_IDLE;
                    NODE_SEND_REQUEST_N <= 1'b1;
                end
            endcase
        end
    end

    // receive deframer; grant simply follows the companion's request
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            NODE_ACCEPT_GRANT_N <= 1'b1;
            RX_DATA             <= 8'h00;
            RX_VALID            <= 1'b0;
            RX_END              <= 1'b0;
            RX_ERR              <= 1'b0;
            rx_esc              <= 1'b0;
            rx_any              <= 1'b0;
        end else begin
            NODE_ACCEPT_GRANT_N <= req_s;
            RX_VALID            <= 1'b0;
            RX_END              <= 1'b0;
            RX_ERR              <= ch.rx_ferr;
            if (ch.rx_strobe && !ch.rx_ferr) begin
                if (ch.rx_byte == `AUF_FLAG) begin
                    RX_END <= rx_any;
                    rx_any <= 1'b0;
                    rx_esc <= 1'b0;
                end else if (ch.rx_byte == `AUF_ESC) begin
                    rx_esc <= 1'b1;
                end else begin
                    RX_DATA  <= rx_esc ? (ch.rx_byte ^ `AUF_XOR) : ch.rx_byte;
                    RX_VALID <= 1'b1;
                    rx_esc   <= 1'b0;
                    rx_any   <= 1'b1;
                end
            end
        end
    end

    // awake while any line or transfer is active, else lowest power
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            AWAKE <= 1'b0;
        end else begin
            AWAKE <= (st != auf_pkg::TX_IDLE) || ch.rx_active || !req_s
                     || ch.rx_strobe || TX_VALID;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sent_esc <= 1'b0;
        end else if (ch.tx_start) begin
            sent_esc <= (ch.tx_byte == `AUF_ESC);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_rts_release;
        NODE_SEND_REQUEST_N && st == auf_pkg::TX_GAP;
    endsequence

    chk_request_before_char: assert property (ch.tx_start |-> !NODE_SEND_REQUEST_N)
        else $error("character sent without send request");

    chk_no_pause_data: assert property (st == auf_pkg::TX_DATA && hold_valid && can_issue
        |=> ch.tx_start)
        else $error("held byte not sent at once");

    chk_request_release: assert property (st == auf_pkg::TX_FIN && can_issue
        |=> s_rts_release ##1 NODE_SEND_REQUEST_N)
        else $error("send request not released after packet");

    chk_gap_hold: assert property (st == auf_pkg::TX_GAP |-> NODE_SEND_REQUEST_N)
        else $error("send request lowered inside gap");

    chk_gap_length: assert property ($rose(NODE_SEND_REQUEST_N)
        |-> gap_cnt == GW'(GAP_CYCLES - 1))
        else $error("gap counter not loaded");

    chk_escape_pair: assert property (ch.tx_start && sent_esc
        |-> ch.tx_byte == (`AUF_FLAG ^ `AUF_XOR) || ch.tx_byte == (`AUF_ESC ^ `AUF_XOR))
        else $error("escape not followed by transformed byte");

    chk_grant_follows: assert property (!req_s |=> !NODE_ACCEPT_GRANT_N)
        else $error("grant did not follow request");

    chk_wake_on_pin: assert property (!req_s |=> AWAKE)
        else $error("port stayed asleep on request");

    chk_rx_unescape: assert property (ch.rx_strobe && !ch.rx_ferr && rx_esc
        && !needs_escape(ch.rx_byte)
        |=> RX_VALID && RX_DATA == ($past(ch.rx_byte) ^ `AUF_XOR))
        else $error("escaped byte not restored");

    chk_asleep_idle: assert property (st == auf_pkg::TX_IDLE && !ch.rx_active && req_s
        && !ch.rx_strobe && !TX_VALID |=> !AWAKE)
        else $error("port did not return to low power");

endmodule

// [verification/auf_host_model.sv]
`timescale 1ns/1ps
module auf_host_model #(
    parameter int BIT_CYCLES = 16
) (
    input  wire logic clk,
    input  wire logic txd,
    input  wire logic node_send_request_n,
    output logic      host_accept_grant_n,
    output logic      rxd,
    output logic      host_send_request_n,
    input  wire logic node_accept_grant_n
);
    auf_pkg::auf_byte_t line_q[$];
    int                 grant_delay   = 2;
    bit                 always_ready  = 1'b1;
    bit                 use_handshake = 1'b1;
    bit                 in_pkt        = 1'b0;
    int                 wait_cnt      = 0;
    int                 order_err     = 0;
    logic [7:0]         sh;

    initial begin
        host_accept_grant_n = 1'b1;
        rxd = 1'b1;
        host_send_request_n = 1'b1;
    end

    // grant after a delay; withdrawn at first character unless always ready
    always @(negedge clk) begin
        if (node_send_request_n) begin
            host_accept_grant_n <= 1'b1;
            wait_cnt <= 0;
            in_pkt <= 1'b0;
        end else if (in_pkt && !always_ready) begin
            host_accept_grant_n <= 1'b1;
        end else if (wait_cnt >= grant_delay) begin
            host_accept_grant_n <= 1'b0;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end

    // character receiver; start bit only legal while requested, first one of a packet also only while granted
    initial begin
        forever begin
            @(negedge clk);
            if (txd === 1'b0) begin
                if (node_send_request_n !== 1'b0 || (!in_pkt && host_accept_grant_n !== 1'b0))
                    order_err++;
                in_pkt = 1'b1;
                repeat (BIT_CYCLES / 2) @(negedge clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYCLES) @(negedge clk);
                    sh[i] = txd;
                end
                repeat (BIT_CYCLES) @(negedge clk);
                if (txd !== 1'b1)
                    order_err++;
                line_q.push_back(sh);
            end
        end
    end

    task automatic put_char(input auf_pkg::auf_byte_t b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd = f[i];
            repeat (BIT_CYCLES) @(negedge clk);
        end
    endtask

    // bad_at: index of the encoded character sent with a low stop bit
    task automatic send_frame(input auf_pkg::auf_byte_t p[$], input int bad_at);
        auf_pkg::auf_byte_t e[$];
        int                 n;
        e.push_back(8'h7e);
        foreach (p[i]) begin
            if (p[i] == 8'h7e || p[i] == 8'h7d) begin
                e.push_back(8'h7d);
                e.push_back(p[i] ^ 8'h20);
            end else begin
                e.push_back(p[i]);
            end
        end
        e.push_back(8'h7e);
        if (use_handshake) begin
            host_send_request_n = 1'b0;
            n = 0;
            while (node_accept_grant_n !== 1'b0 && n < 100) begin
                @(negedge clk);
                n++;
            end
            if (n >= 100)
                order_err++;
        end
        foreach (e[i]) put_char(e[i], i != bad_at);
        host_send_request_n = 1'b1;
        repeat (2 * BIT_CYCLES) @(negedge clk);
    endtask
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
    localparam int BIT_CYCLES = 16;
    localparam int GAP_CYCLES = 20;

    logic               clk = 1'b0;
    logic               sys_rst;
    logic               rxd, host_send_request_n, node_accept_grant_n;
    logic               txd, node_send_request_n, host_accept_grant_n;
    auf_pkg::auf_byte_t tx_data;
    logic               tx_valid;
    logic               tx_last;
    logic               tx_ready, rx_valid, rx_end, rx_err, awake;
    auf_pkg::auf_byte_t rx_data;
    auf_pkg::auf_byte_t rx_q[$];
    auf_pkg::auf_byte_t exp_q[$];
    int                 end_cnt, ferr_cnt, hi_run, min_gap = 1000000;
    bit                 awake_seen;
    int                 err_count, n_compared;

    always #12.5 clk = ~clk;

    auf_link #(.BIT_CYCLES(BIT_CYCLES), .GAP_CYCLES(GAP_CYCLES)) i_auf_link (
        .CLK(clk), .SYS_RST(sys_rst), .RXD(rxd), .HOST_SEND_REQUEST_N(host_send_request_n),
        .NODE_ACCEPT_GRANT_N(node_accept_grant_n), .TXD(txd),
        .NODE_SEND_REQUEST_N(node_send_request_n), .HOST_ACCEPT_GRANT_N(host_accept_grant_n),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_LAST(tx_last), .TX_READY(tx_ready),
        .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_END(rx_end), .RX_ERR(rx_err),
        .AWAKE(awake));

    auf_host_model #(.BIT_CYCLES(BIT_CYCLES)) i_auf_host_model (
        .clk(clk), .txd(txd), .node_send_request_n(node_send_request_n),
        .host_accept_grant_n(host_accept_grant_n), .rxd(rxd),
        .host_send_request_n(host_send_request_n), .node_accept_grant_n(node_accept_grant_n));

    // receive monitor and request idle-run measurement
    always @(negedge clk) begin
        if (!sys_rst) begin
            if (rx_valid === 1'b1)
                rx_q.push_back(rx_data);
            if (rx_end === 1'b1)
                end_cnt++;
            if (rx_err === 1'b1)
                ferr_cnt++;
            if (awake === 1'b1)
                awake_seen = 1'b1;
            if (node_send_request_n === 1'b1) begin
                hi_run++;
            end else begin
                if (hi_run > 0 && hi_run < min_gap)
                    min_gap = hi_run;
                hi_run = 0;
            end
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("compared=%0d errors=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic send_packet(input auf_pkg::auf_byte_t p[$]);
        int n;
        foreach (p[i]) begin
            tx_valid = 1'b1;
            tx_data = p[i];
            tx_last = (i == p.size() - 1);
            n = 0;
            while (tx_ready !== 1'b1 && n < 5000) begin
                @(negedge clk);
                n++;
            end
            check(tx_ready, 1'b1);
            @(negedge clk);
        end
        tx_valid = 1'b0;
        tx_last = 1'b0;
    endtask

    task automatic add_frame(input auf_pkg::auf_byte_t p[$]);
        exp_q.push_back(8'h7e);
        foreach (p[i]) begin
            if (p[i] == 8'h7e || p[i] == 8'h7d) begin
                exp_q.push_back(8'h7d);
                exp_q.push_back(p[i] ^ 8'h20);
            end else begin
                exp_q.push_back(p[i]);
            end
        end
        exp_q.push_back(8'h7e);
    endtask

    task automatic expect_line;
        int n;
        n = 0;
        while (i_auf_host_model.line_q.size() < exp_q.size() && n < 20000) begin
            @(negedge clk);
            n++;
        end
        // closing stop bit still on the line when it is pushed
        repeat (BIT_CYCLES) @(negedge clk);
        check(i_auf_host_model.line_q.size(), exp_q.size());
        foreach (exp_q[i]) check(i_auf_host_model.line_q[i], exp_q[i]);
        check(node_send_request_n, 1'b1);
        check(i_auf_host_model.order_err, 0);
        i_auf_host_model.line_q.delete();
        exp_q.delete();
    endtask

    task automatic expect_rx(input auf_pkg::auf_byte_t p[$], input int ends, input int errs);
        check(rx_q.size(), p.size());
        foreach (p[i]) check(rx_q[i], p[i]);
        check(end_cnt, ends);
        check(ferr_cnt, errs);
        rx_q.delete();
        end_cnt = 0;
        ferr_cnt = 0;
    endtask

    task automatic t_reset;
        check({txd, node_send_request_n, node_accept_grant_n}, 3'h7);
        check({tx_ready, rx_valid, rx_end, rx_err, awake}, 5'h00);
    endtask

    // slow grant withdrawn after the first character
    task automatic t_tx_escape;
        i_auf_host_model.always_ready = 1'b0;
        i_auf_host_model.grant_delay = 30;
        send_packet('{8'h11, 8'h7e, 8'h7d, 8'h22});
        add_frame('{8'h11, 8'h7e, 8'h7d, 8'h22});
        expect_line();
    endtask

    // always-ready companion, packets queued back to back
    task automatic t_tx_back2back;
        i_auf_host_model.always_ready = 1'b1;
        i_auf_host_model.grant_delay = 0;
        min_gap = 1000000;
        send_packet('{8'ha5});
        @(negedge clk);
        send_packet('{8'h00, 8'hff});
        add_frame('{8'ha5});
        add_frame('{8'h00, 8'hff});
        expect_line();
        check(min_gap >= GAP_CYCLES, 1'b1);
    endtask

    task automatic t_rx(input bit hs, input int bad_at);
        i_auf_host_model.use_handshake = hs;
        awake_seen = 1'b0;
        check(node_accept_grant_n, 1'b1);
        if (bad_at < 0)
            i_auf_host_model.send_frame('{8'h33, 8'h7e, 8'h44, 8'h7d}, bad_at);
        else
            i_auf_host_model.send_frame('{8'h01, 8'h02}, bad_at);
        repeat (40) @(negedge clk);
        check(i_auf_host_model.order_err, 0);
        check(awake_seen, 1'b1);
        check(awake, 1'b0);
        if (bad_at < 0)
            expect_rx('{8'h33, 8'h7e, 8'h44, 8'h7d}, 1, 0);
        else
            expect_rx('{8'h01}, 1, 1);
        check(node_accept_grant_n, 1'b1);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        give_verdict();
    end

    initial begin
        sys_rst = 1'b1;
        tx_data = 8'h00;
        tx_valid = 1'b0;
        tx_last = 1'b0;
        repeat (10) @(negedge clk);
        t_reset();
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge clk);
        t_tx_escape();
        t_tx_back2back();
        t_rx(1'b1, -1);
        t_rx(1'b0, -1);
        t_rx(1'b1, 2);
        give_verdict();
    end
endmodule
